// ===== hdl/ubs_pkg.sv
// Behaviour
// - With filtering on, data frames are dropped: not stored, no receive-done.
// - Transmitter ignores the filter enable completely.
// - Frame type is first stop bit for 5-8 bits, ninth bit for 9.
// - Frame type one means address frame, zero means data frame.
// - Data writes fill the transmit buffer; data reads return receive data.
// - For 5-7 bit characters unused upper bits are ignored and read zero.
// - Data write while transmit buffer is not empty is ignored.
// - Enabled transmitter moves held data into an empty shifter and sends it.
// - Receive buffer is a two-entry FIFO advanced by data reads.
// - Receive-done shows unread data; receiver disable flushes the FIFO.
// - Transmit-done sets after last frame with buffer empty; ack or one clears.
// - Transmit-buffer-empty reads one when buffer free, and after reset.
// - Framing error shows zero first stop bit of the oldest unread character.
// - Overrun sets on full FIFO, waiting character and a new start bit.
// - Parity error shows failed check of oldest character when checking on.
// - Double-rate cuts the baud divider from 16 to 8.
// - Receive-done, transmit-done and buffer-empty can each request interrupts.
// - Accepted address frames are stored and raise receive-done normally.
package ubs_pkg;
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CSA = 8'h04;
    localparam logic [7:0] OFS_CSB = 8'h08;
    localparam logic [7:0] OFS_CSC = 8'h0C;
    localparam logic [7:0] OFS_BAUD = 8'h10;
    localparam int CSA_TXDONE = 6;
    localparam int CSA_DBL = 1;
    localparam int CSA_FILT = 0;
    localparam int CSB_IRQ_HI = 7;
    localparam int CSB_IRQ_LO = 5;
    localparam int CSB_RXEN = 4;
    localparam int CSB_TXEN = 3;
    localparam int CSB_SIZE2 = 2;
    localparam int CSB_TXNINTH = 0;
    localparam int CSC_PAR_HI = 5;
    localparam int CSC_PAR_LO = 4;
    localparam int CSC_STOP2 = 3;
    localparam int CSC_SIZE_HI = 2;
    localparam int CSC_SIZE_LO = 1;
    localparam logic [1:0] CSC_SIZE_RST = 2'h3;
    localparam logic [11:0] BAUD_RST = 12'h000;
    localparam logic [3:0] DIV_NORMAL = 4'hF;
    localparam logic [3:0] DIV_DOUBLE = 4'h7;
    localparam logic [3:0] HALF_NORMAL = 4'h7;
    localparam logic [3:0] HALF_DOUBLE = 4'h3;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic frameErr;
        logic parityErr;
    } ubs_rx_entry_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS = 4'b0100,
        RX_STOP = 4'b1000
    } ubs_rx_state_t;
endpackage

// ===== hdl/ubs_uart_core.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module ubs_uart_core
    import ubs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialInLine,
    output logic serialOutLine,
    output logic serialOutEn,
    input wire logic txDoneAck,
    output logic rxDoneIrq,
    output logic txDoneIrq,
    output logic txEmptyIrq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic filterEn_q, doubleRate_q, txDone_q;
    logic [2:0] irqEn_q;
    logic rxEn_q, txEn_q, size2_q, txNinth_q;
    logic [1:0] parMode_q, size10_q;
    logic stop2_q;
    logic [11:0] baud_q, presc_q;
    logic [8:0] holdData_q;
    logic holdFull_q;
    logic [12:0] txShift_q;
    logic [3:0] txLeft_q, txSample_q;
    logic txBusy_q, txOut_q, txOutEn_q;
    ubs_rx_state_t rxState_q;
    logic [3:0] rxSample_q, rxBit_q;
    logic [11:0] rxFrame_q;
    ubs_rx_entry_t pend_q;
    logic pendValid_q;
    ubs_rx_entry_t fifo_q [2];
    logic rdPtr_q;
    logic [1:0] count_q;
    logic overrun_q;
    logic rxIrq_q, txIrq_q, emptyIrq_q;

    wire access = psel && penable;
    wire done = access && pready_q;
    wire wrDone = done && pwrite;
    wire rdDone = done && !pwrite;
    wire selData = paddr == OFS_DATA;
    wire selCsa = paddr == OFS_CSA;
    wire selCsb = paddr == OFS_CSB;
    wire selCsc = paddr == OFS_CSC;
    wire selBaud = paddr == OFS_BAUD;
    wire hit = selData || selCsa || selCsb || selCsc || selBaud;

    // Character geometry shared by both directions
    wire [2:0] sizeCode = {size2_q, size10_q};
    wire [3:0] nData = (sizeCode == SIZE_NINE) ? 4'd9 :
        (sizeCode[2] ? 4'd8 : 4'd5 + {2'b00, sizeCode[1:0]});
    wire nine = sizeCode == SIZE_NINE;
    wire parOn = parMode_q[1];
    wire [3:0] divLast = doubleRate_q ? DIV_DOUBLE : DIV_NORMAL;
    wire [3:0] halfPt = doubleRate_q ? HALF_DOUBLE : HALF_NORMAL;
    wire tick = presc_q == 12'h000;
    logic [8:0] dataMask;
    for (genvar i = 0; i < 9; i++)
    begin : g_mask
        assign dataMask[i] = 4'(i) < nData;
    end

    ////////////////////////////////////////////////////////////////////
    // Register bus: one wait state so read data leaves a flip-flop
    wire ubs_rx_entry_t head = fifo_q[rdPtr_q];
    wire nonEmpty = count_q != 2'd0;
    wire [7:0] csaView = {nonEmpty, txDone_q, !holdFull_q,
        head.frameErr && nonEmpty, overrun_q,
        head.parityErr && nonEmpty, doubleRate_q, filterEn_q};
    wire [7:0] csbView = {irqEn_q, rxEn_q, txEn_q, size2_q,
        head.ninth, txNinth_q};
    wire [7:0] cscView = {2'b00, parMode_q, stop2_q, size10_q, 1'b0};
    wire [31:0] rdMux = selData ? {24'h000000, head.data} :
        selCsa ? {24'h000000, csaView} :
        selCsb ? {24'h000000, csbView} :
        selCsc ? {24'h000000, cscView} :
        selBaud ? {20'h00000, baud_q} : 32'h00000000;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= access && !pready_q;
            if (access && !pready_q)
            begin
                pslverr_q <= !hit;
                prdata_q <= pwrite ? 32'h00000000 : rdMux;
            end
        end
    end

    // Error bits of the status word are never stored from a write
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            filterEn_q <= 1'b0;
            doubleRate_q <= 1'b0;
            irqEn_q <= 3'h0;
            rxEn_q <= 1'b0;
            txEn_q <= 1'b0;
            size2_q <= 1'b0;
            txNinth_q <= 1'b0;
            parMode_q <= 2'h0;
            stop2_q <= 1'b0;
            size10_q <= CSC_SIZE_RST;
            baud_q <= BAUD_RST;
        end
        else if (wrDone)
        begin
            if (selCsa)
            begin
                filterEn_q <= pwdata[CSA_FILT];
                doubleRate_q <= pwdata[CSA_DBL];
            end
            if (selCsb)
            begin
                irqEn_q <= pwdata[CSB_IRQ_HI:CSB_IRQ_LO];
                rxEn_q <= pwdata[CSB_RXEN];
                txEn_q <= pwdata[CSB_TXEN];
                size2_q <= pwdata[CSB_SIZE2];
                txNinth_q <= pwdata[CSB_TXNINTH];
            end
            if (selCsc)
            begin
                parMode_q <= pwdata[CSC_PAR_HI:CSC_PAR_LO];
                stop2_q <= pwdata[CSC_STOP2];
                size10_q <= pwdata[CSC_SIZE_HI:CSC_SIZE_LO];
            end
            if (selBaud)
                baud_q <= pwdata[11:0];
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            presc_q <= 12'h000;
        else
            presc_q <= tick ? baud_q : presc_q - 12'h001;
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter; filter enable is deliberately not an input here
    wire holdWr = wrDone && selData && !holdFull_q;
    wire txLoad = txEn_q && !txBusy_q && holdFull_q;
    wire txStep = txBusy_q && tick && txSample_q == divLast;
    wire txFinish = txStep && txLeft_q == 4'd0;
    wire [8:0] txData = holdData_q & dataMask;
    wire txPar = (^txData) ^ parMode_q[0];
    wire [3:0] txTotal = 4'd2 + nData + {3'b000, parOn} + {3'b000, stop2_q};
    logic [12:0] txFrame;

    always_comb
    begin
        txFrame = '1;
        txFrame[0] = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            if (dataMask[i])
                txFrame[i + 1] = txData[i];
        end
        if (parOn)
            txFrame[nData + 4'd1] = txPar;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            holdData_q <= 9'h000;
            holdFull_q <= 1'b0;
            txShift_q <= '1;
            txLeft_q <= 4'h0;
            txSample_q <= 4'h0;
            txBusy_q <= 1'b0;
            txOut_q <= 1'b1;
            txOutEn_q <= 1'b0;
            txDone_q <= 1'b0;
        end
        else
        begin
            txOutEn_q <= txEn_q || txBusy_q || holdFull_q;
            if (holdWr)
            begin
                holdData_q <= {txNinth_q, pwdata[7:0]};
                holdFull_q <= 1'b1;
            end
            else if (txLoad)
                holdFull_q <= 1'b0;
            if (txLoad)
            begin
                txOut_q <= txFrame[0];
                txShift_q <= txFrame >> 1;
                txLeft_q <= txTotal - 4'd1;
                txSample_q <= 4'h0;
                txBusy_q <= 1'b1;
            end
            else if (txFinish)
                txBusy_q <= 1'b0;
            else if (txStep)
            begin
                txOut_q <= txShift_q[0];
                txShift_q <= {1'b1, txShift_q[12:1]};
                txLeft_q <= txLeft_q - 4'd1;
                txSample_q <= 4'h0;
            end
            else if (txBusy_q && tick)
                txSample_q <= txSample_q + 4'd1;
            // Set beats a clear in the same cycle
            if (txFinish && !holdFull_q)
                txDone_q <= 1'b1;
            else if (txDoneAck || (wrDone && selCsa && pwdata[CSA_TXDONE]))
                txDone_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receiver: single centre sample per bit, no majority vote
    wire startSeen = rxState_q == RX_IDLE && rxEn_q && !serialInLine;
    wire frameEnd = rxState_q == RX_STOP;
    wire [3:0] nBits = nData + {3'b000, parOn} + 4'd1;
    wire [3:0] stopIdx = nData + {3'b000, parOn};
    wire [8:0] rxData = rxFrame_q[8:0] & dataMask;
    wire stopBit = rxFrame_q[stopIdx];
    wire frameType = nine ? rxFrame_q[8] : stopBit;
    wire isAddr = frameType;
    wire accept = !(filterEn_q && !isAddr);
    ubs_rx_entry_t rxEntry;
    assign rxEntry.data = rxData[7:0];
    assign rxEntry.ninth = nine && rxData[8];
    assign rxEntry.frameErr = !stopBit;
    assign rxEntry.parityErr = parOn &&
        (rxFrame_q[nData] != ((^rxData) ^ parMode_q[0]));
    wire push = pendValid_q && count_q != 2'd2;
    wire pop = rdDone && selData && nonEmpty;
    wire wrIdx = rdPtr_q ^ count_q[0];

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            rxState_q <= RX_IDLE;
            rxSample_q <= 4'h0;
            rxBit_q <= 4'h0;
            rxFrame_q <= 12'h000;
        end
        else if (!rxEn_q)
            rxState_q <= RX_IDLE;
        else
        begin
            case (rxState_q)
                RX_IDLE:
                begin
                    rxSample_q <= 4'h0;
                    rxBit_q <= 4'h0;
                    if (startSeen)
                        rxState_q <= RX_START;
                end
                RX_START:
                begin
                    if (tick && rxSample_q == halfPt)
                    begin
                        rxSample_q <= 4'h0;
                        rxState_q <= serialInLine ? RX_IDLE : RX_BITS;
                    end
                    else if (tick)
                        rxSample_q <= rxSample_q + 4'd1;
                end
                RX_BITS:
                begin
                    if (tick && rxSample_q == divLast)
                    begin
                        rxSample_q <= 4'h0;
                        rxFrame_q[rxBit_q] <= serialInLine;
                        rxBit_q <= rxBit_q + 4'd1;
                        if (rxBit_q == nBits - 4'd1)
                            rxState_q <= RX_STOP;
                    end
                    else if (tick)
                        rxSample_q <= rxSample_q + 4'd1;
                end
                RX_STOP:
                    rxState_q <= RX_IDLE;
                default:
                    rxState_q <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pend_q <= '0;
            pendValid_q <= 1'b0;
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
            rdPtr_q <= 1'b0;
            count_q <= 2'd0;
            overrun_q <= 1'b0;
        end
        else if (!rxEn_q)
        begin
            pendValid_q <= 1'b0;
            count_q <= 2'd0;
            overrun_q <= 1'b0;
        end
        else
        begin
            if (frameEnd && accept)
            begin
                pend_q <= rxEntry;
                pendValid_q <= 1'b1;
            end
            else if (push)
                pendValid_q <= 1'b0;
            if (push)
                fifo_q[wrIdx] <= pend_q;
            if (pop)
                rdPtr_q <= !rdPtr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
            if (startSeen && count_q == 2'd2 && pendValid_q)
                overrun_q <= 1'b1;
            else if (pop)
                overrun_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            rxIrq_q <= 1'b0;
            txIrq_q <= 1'b0;
            emptyIrq_q <= 1'b0;
        end
        else
        begin
            rxIrq_q <= irqEn_q[2] && nonEmpty;
            txIrq_q <= irqEn_q[1] && txDone_q;
            emptyIrq_q <= irqEn_q[0] && !holdFull_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign serialOutLine = txOut_q;
    assign serialOutEn = txOutEn_q;
    assign rxDoneIrq = rxIrq_q;
    assign txDoneIrq = txIrq_q;
    assign txEmptyIrq = emptyIrq_q;

    ////////////////////////////////////////////////////////////////////
    sequence s_dataDrop;
        frameEnd && filterEn_q && !isAddr && !pendValid_q && rxEn_q;
    endsequence
    property p_filter_drop;
        s_dataDrop |=> !pendValid_q && count_q == $past(count_q) - {1'b0, $past(pop)};
    endproperty
    a_filter_drop: assert property (p_filter_drop) else $error("data frame kept");
    property p_addr_kept;
        frameEnd && isAddr && rxEn_q |=> pendValid_q && pend_q == $past(rxEntry);
    endproperty
    a_addr_kept: assert property (p_addr_kept) else $error("address lost");
    property p_hold_ignored;
        wrDone && selData && holdFull_q && !txLoad |=> $stable(holdData_q) && holdFull_q;
    endproperty
    a_hold_ignored: assert property (p_hold_ignored) else $error("full write taken");
    sequence s_load;
        txLoad ##1 txBusy_q && !txOut_q;
    endsequence
    property p_load;
        txLoad |-> s_load;
    endproperty
    a_load: assert property (p_load) else $error("no start bit");
    property p_flush;
        $fell(rxEn_q) |=> count_q == 2'd0 ##1 !rxIrq_q;
    endproperty
    a_flush: assert property (p_flush) else $error("flush failed");
    property p_txdone;
        txFinish && !holdFull_q |=> txDone_q;
    endproperty
    a_txdone: assert property (p_txdone) else $error("txdone missing");
    property p_overrun;
        startSeen && count_q == 2'd2 && pendValid_q |=> overrun_q;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");
    property p_pop;
        pop && !push |=> count_q == $past(count_q) - 2'd1;
    endproperty
    a_pop: assert property (p_pop) else $error("fifo did not pop");
    property p_upper_zero;
        frameEnd && sizeCode == 3'h0 |-> rxEntry.data[7:5] == 3'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
endmodule

// ===== testbench/test_uart_buffer_status_addr_filter.sv
`timescale 1ns/1ps
module test_uart_buffer_status_addr_filter;
    import ubs_pkg::*;
    logic mclk;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic txDoneAck;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic pready;
    logic pslverr;
    logic rdErr;
    logic serialInLine;
    logic serialOutLine;
    logic serialOutEn;
    logic rxDoneIrq;
    logic txDoneIrq;
    logic txEmptyIrq;
    int fails = 0;
    int comparisons = 0;

    ubs_uart_core i_dut (
        .mclk(mclk),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .serialInLine(serialInLine),
        .serialOutLine(serialOutLine),
        .serialOutEn(serialOutEn),
        .txDoneAck(txDoneAck),
        .rxDoneIrq(rxDoneIrq),
        .txDoneIrq(txDoneIrq),
        .txEmptyIrq(txEmptyIrq)
    );

    ubs_serial_peer i_peer (
        .mclk(mclk),
        .lineOut(serialInLine),
        .lineIn(serialOutLine)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Request held until pready is sampled high; read data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] mask,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rdv & mask);
    endtask

    task automatic waitRx(input int cnt);
        int n;
        n = 0;
        while (i_peer.rxCount < cnt && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 3000)
        begin
            fails++;
            summarize();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Status writes always carry zeros in the error positions and whole values
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        txDoneAck = 1'b0;
        reset = 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rdChk("csa", OFS_CSA, 32'hFFFFFFFF, 32'h20);
        check("outEnOff", 32'h0, {31'h0, serialOutEn});
        rdChk("csc", OFS_CSC, 32'hFFFFFFFF, 32'h06);
        rdChk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
        check("pslverr", 32'h1, {31'h0, rdErr});
        wr(OFS_CSB, 32'h38);
        repeat (2) @(posedge mclk);
        check("txEmptyIrq", 32'h1, {31'h0, txEmptyIrq});
        check("outEnOn", 32'h1, {31'h0, serialOutEn});
        // Third write lands while the second byte is still held
        wr(OFS_DATA, 32'h11);
        wr(OFS_DATA, 32'h22);
        wr(OFS_DATA, 32'h33);
        rdChk("bufEmpty", OFS_CSA, 32'h20, 32'h0);
        waitRx(2);
        repeat (400) @(posedge mclk);
        check("tx0", 32'h111, {22'h0, i_peer.rxLog[0]});
        check("tx1", 32'h122, {22'h0, i_peer.rxLog[1]});
        check("txCount", 32'h2, i_peer.rxCount);
        rdChk("txDone", OFS_CSA, 32'h60, 32'h60);
        wr(OFS_CSA, 32'h40);
        rdChk("txDoneW1C", OFS_CSA, 32'h40, 32'h0);
        i_peer.sendFrame(10'h05A, 8, 1'b1);
        rdChk("rxDone", OFS_CSA, 32'h9C, 32'h80);
        rdChk("rxData", OFS_DATA, 32'hFFFFFFFF, 32'h5A);
        rdChk("rxEmpty", OFS_CSA, 32'h80, 32'h0);
        i_peer.sendFrame(10'h03C, 8, 1'b0);
        rdChk("frameErr", OFS_CSA, 32'h10, 32'h10);
        rdChk("feData", OFS_DATA, 32'hFF, 32'h3C);
        // Two in the FIFO, one waiting in pend_q, then a fourth start bit
        i_peer.sendFrame(10'h001, 8, 1'b1);
        i_peer.sendFrame(10'h002, 8, 1'b1);
        i_peer.sendFrame(10'h003, 8, 1'b1);
        i_peer.sendFrame(10'h004, 8, 1'b1);
        rdChk("overrun", OFS_CSA, 32'h98, 32'h88);
        rdChk("fifo0", OFS_DATA, 32'hFF, 32'h01);
        rdChk("fifo1", OFS_DATA, 32'hFF, 32'h02);
        wr(OFS_CSB, 32'h08);
        rdChk("flush", OFS_CSA, 32'h80, 32'h0);
        wr(OFS_CSC, 32'h26);
        wr(OFS_CSB, 32'h18);
        i_peer.sendFrame(10'h001, 9, 1'b1);
        rdChk("parityErr", OFS_CSA, 32'h14, 32'h04);
        rdChk("peData", OFS_DATA, 32'hFF, 32'h01);
        wr(OFS_CSC, 32'h06);
        wr(OFS_CSB, 32'h1C);
        wr(OFS_CSA, 32'h01);
        i_peer.sendFrame(10'h055, 9, 1'b1);
        rdChk("dropData", OFS_CSA, 32'h80, 32'h0);
        i_peer.sendFrame(10'h1A3, 9, 1'b1);
        rdChk("addrDone", OFS_CSA, 32'h80, 32'h80);
        rdChk("rxNinth", OFS_CSB, 32'h02, 32'h02);
        rdChk("addrData", OFS_DATA, 32'hFFFFFFFF, 32'hA3);
        i_peer.rxBits = 9;
        // Receive-done and transmit-done interrupt enables on from here
        wr(OFS_CSB, 32'hDD);
        wr(OFS_DATA, 32'h96);
        waitRx(3);
        repeat (40) @(posedge mclk);
        check("tx9", 32'h396, {22'h0, i_peer.rxLog[2]});
        rdChk("txDone9", OFS_CSA, 32'h40, 32'h40);
        check("txDoneIrq", 32'h1, {31'h0, txDoneIrq});
        @(posedge mclk);
        txDoneAck <= 1'b1;
        @(posedge mclk);
        txDoneAck <= 1'b0;
        rdChk("txDoneAck", OFS_CSA, 32'h40, 32'h0);
        check("txDoneIrqOff", 32'h0, {31'h0, txDoneIrq});
        wr(OFS_CSA, 32'h00);
        i_peer.sendFrame(10'h077, 9, 1'b1);
        check("rxDoneIrq", 32'h1, {31'h0, rxDoneIrq});
        rdChk("ninthZero", OFS_CSB, 32'h02, 32'h0);
        rdChk("dataAfter", OFS_DATA, 32'hFFFFFFFF, 32'h77);
        // Five-bit frames: type rides in the first stop bit
        wr(OFS_CSC, 32'h00);
        check("rxDoneIrqOff", 32'h0, {31'h0, rxDoneIrq});
        wr(OFS_CSB, 32'h18);
        wr(OFS_CSA, 32'h01);
        i_peer.sendFrame(10'h00A, 5, 1'b0);
        rdChk("drop5", OFS_CSA, 32'h80, 32'h0);
        i_peer.sendFrame(10'h01F, 5, 1'b1);
        rdChk("rx5", OFS_DATA, 32'hFFFFFFFF, 32'h1F);
        i_peer.rxBits = 5;
        wr(OFS_DATA, 32'hE3);
        waitRx(4);
        check("tx5", 32'h023, {22'h0, i_peer.rxLog[3]});
        summarize();
    end
endmodule

// ===== testbench/ubs_serial_peer.sv
`timescale 1ns/1ps
module ubs_serial_peer
(
    input wire logic mclk,
    output logic lineOut,
    input wire logic lineIn
);
    int rxBits = 8;
    int rxCount = 0;
    logic [9:0] rxLog [0:7];

    initial lineOut = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bitOut(input logic b);
        @(posedge mclk);
        lineOut <= b;
        repeat (15) @(posedge mclk);
    endtask

    // Ninth bit or first stop bit carries the frame type; a second stop always follows
    task automatic sendFrame(input logic [9:0] bits, input int n, input logic stop1);
        bitOut(1'b0);
        for (int i = 0; i < n; i++)
            bitOut(bits[i]);
        bitOut(stop1);
        bitOut(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Captures data bits and the first stop bit, sampled at bit centre
    initial
    begin
        forever
        begin
            @(posedge mclk iff lineIn === 1'b0);
            repeat (8) @(posedge mclk);
            rxLog[rxCount] = 10'h000;
            for (int i = 0; i <= rxBits; i++)
            begin
                repeat (16) @(posedge mclk);
                rxLog[rxCount][i] = lineIn;
            end
            rxCount++;
        end
    end
endmodule
